// File: design/port_pkg.sv
package port_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_WRITE = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h1;
    localparam logic [3:0] CMD_LINE_RD = 4'h2;
    localparam logic [3:0] CMD_LINE_WR = 4'h3;
    localparam logic [3:0] CMD_FLUSH = 4'h4;
    localparam logic [3:0] CMD_NV_ADDR = 4'h5;
    localparam logic [3:0] CMD_NV_WR = 4'h6;
    localparam logic [3:0] CMD_NV_RD = 4'h7;
    localparam logic [3:0] CMD_USB_STATE = 4'h8;
    // ------------------------------------------------------------
    // Command byte layout
    // ------------------------------------------------------------
    localparam int CMD3_POS = 0;
    localparam int CMD2_POS = 3;
    localparam int CMD1_POS = 5;
    localparam int CMD0_POS = 6;
    localparam int FLAG2_POS = 1;
    localparam int FLAG4_POS = 2;
    localparam int FLAG8_POS = 4;
    localparam int FLAG8_TOP = 7;
    localparam int FLAG4_TOP = 3;
    // ------------------------------------------------------------
    // Widths, status levels, sizes
    // ------------------------------------------------------------
    localparam logic [1:0] WL_1 = 2'h0;
    localparam logic [1:0] WL_2 = 2'h1;
    localparam logic [1:0] WL_4 = 2'h2;
    localparam logic [1:0] WL_8 = 2'h3;
    localparam logic ACK = 1'b0;
    localparam logic NAK = 1'b1;
    localparam logic [3:0] BYTE_W = 4'h8;
    localparam logic [7:0] ALL_LINES = 8'hFF;
    localparam logic [7:0] IDLE_LINE_OE = 8'h01;
    localparam int FIFO_DEPTH = 512;
    localparam int HALF_CYCLES = 8;

    // ------------------------------------------------------------
    // Lane helpers shared by both ends
    // ------------------------------------------------------------
    function automatic logic [3:0] lanes(input logic [1:0] wl);
        lanes = 4'h1 << wl;
    endfunction

    function automatic logic [7:0] lane_mask(input logic [1:0] wl);
        lane_mask = ALL_LINES >> (BYTE_W - lanes(wl));
    endfunction

    // Unused lines show high, as the pull-ups would
    function automatic logic [7:0] lane_out(input logic [7:0] b, input logic [1:0] wl,
                                            input logic lsb);
        logic [7:0] v;
        v = lsb ? (b & lane_mask(wl)) : (b >> (BYTE_W - lanes(wl)));
        lane_out = v | ~lane_mask(wl);
    endfunction

    function automatic logic [7:0] shift_out(input logic [7:0] b, input logic [1:0] wl,
                                             input logic lsb);
        shift_out = lsb ? (b >> lanes(wl)) : (b << lanes(wl));
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic [7:0] d,
                                            input logic [1:0] wl, input logic lsb);
        logic [7:0] m;
        m = d & lane_mask(wl);
        shift_in = lsb ? ((b >> lanes(wl)) | (m << (BYTE_W - lanes(wl))))
                       : ((b << lanes(wl)) | m);
    endfunction

    function automatic logic [2:0] last_chunk(input logic [1:0] wl);
        last_chunk = 3'(BYTE_W >> wl) - 3'h1;
    endfunction
endpackage

// File: design/port_link_if.sv
`timescale 1ns/1ps
interface port_link_if;
    logic link_clk;
    logic sel_n;
    logic [7:0] m_data;
    logic [7:0] m_oe;
    logic [7:0] s_data;
    logic [7:0] s_oe;
    logic s_stat;
    logic s_stat_oe;
    logic [7:0] lines;
    logic stat;

    // ------------------------------------------------------------
    // Wire resolution, undriven lines pulled high
    // ------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_line
        assign lines[i] = m_oe[i] ? m_data[i] : (s_oe[i] ? s_data[i] : 1'b1);
    end
    assign stat = s_stat_oe ? s_stat : 1'b1;

    modport master (output link_clk, output sel_n, output m_data, output m_oe,
                    input lines, input stat);
    modport slave (input link_clk, input sel_n, input lines,
                   output s_data, output s_oe, output s_stat, output s_stat_oe);
endinterface

// File: design/port_slave.sv
`timescale 1ns/1ps
// Operation
// - Data width one, two, four or eight lines
// - Deselected: line zero and status show buffers
// - Idle bits: write room, read data present
// - Command phase first, then data phase
// - Acknowledge or refusal per data byte
// - Many bytes while select stays active
// - Master deselects at once on refusal
// - Command sent full width on first edge
// - Width decoded by priority of low lines
// - Undriven lines read high via pull-ups
// - Command bits at lines 0,3,5,6
// - Four-bit command field, sixteen codes
// - Receive buffer feeds outgoing port bytes
// - Incoming port bytes fill transmit buffer
// - Width switched on every selection
// - Active-low external reset clears logic
// - Protocol logic on internal reference clock
// - Fixed command code table, rest reserved
// - Odd edges drive, even edges sample
// - Phase-one modes only, both idle levels
// - Configurable bit order, LSB or MSB first
module port_slave #(
    parameter int DEPTH = port_pkg::FIFO_DEPTH,
    parameter bit LSB_FIRST = 1'b1
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Link
    port_link_if.slave link,
    // Receive buffer fill from the host side
    input wire logic host_out_valid,
    input wire logic [7:0] host_out_data,
    output logic host_out_ready,
    // Transmit buffer drain to the host side
    output logic host_in_valid,
    output logic [7:0] host_in_data,
    input wire logic host_in_ready,
    // Line state, host state, flush
    input wire logic [7:0] line_state_in,
    output logic [7:0] line_state_out,
    input wire logic [1:0] usb_state,
    output logic flush_req
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [CW-1:0] ONE = CW'(1);

    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} state_t;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [2:0] clk_sync_q;
    logic [1:0] sel_sync_q;
    logic [7:0] d_meta_q;
    logic [7:0] d_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync_q <= 3'h0;
            sel_sync_q <= 2'h3;
            d_meta_q <= 8'hFF;
            d_q <= 8'hFF;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], link.link_clk};
            sel_sync_q <= {sel_sync_q[0], link.sel_n};
            d_meta_q <= link.lines;
            d_q <= d_meta_q;
        end
    end

    // Any transition counts, so both idle levels work alike
    wire link_edge = clk_sync_q[2] ^ clk_sync_q[1];
    wire selected = !sel_sync_q[1];

    state_t state_q;
    logic phase_q;
    logic [3:0] cmd_q;
    logic [1:0] wl_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic ack_q;

    wire drive_edge = (state_q == ST_DATA) && link_edge && !phase_q;
    wire sample_edge = (state_q == ST_DATA) && link_edge && phase_q;
    wire last = (cnt_q == port_pkg::last_chunk(wl_q));
    wire [7:0] in_byte = port_pkg::shift_in(sh_q, d_q, wl_q, LSB_FIRST);

    // ------------------------------------------------------------
    // Buffers
    // ------------------------------------------------------------
    logic [7:0] rx_mem [DEPTH];
    logic [7:0] tx_mem [DEPTH];
    logic [PW-1:0] rx_wr_q, rx_rd_q, tx_wr_q, tx_rd_q;
    logic [CW-1:0] rx_cnt_q, tx_cnt_q, rx_cnt_d, tx_cnt_d;
    logic rx_pop, tx_push;
    wire rx_push = host_out_valid && host_out_ready;
    wire tx_pop = host_in_valid && host_in_ready;

    always_comb begin
        rx_cnt_d = rx_cnt_q + (rx_push ? ONE : '0) - (rx_pop ? ONE : '0);
        tx_cnt_d = tx_cnt_q + (tx_push ? ONE : '0) - (tx_pop ? ONE : '0);
    end

    always_ff @(posedge clock) begin
        if (rx_push) begin
            rx_mem[rx_wr_q] <= host_out_data;
        end
        if (tx_push) begin
            tx_mem[tx_wr_q] <= in_byte;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_wr_q <= '0;
            rx_rd_q <= '0;
            tx_wr_q <= '0;
            tx_rd_q <= '0;
            rx_cnt_q <= '0;
            tx_cnt_q <= '0;
            host_out_ready <= 1'b0;
            host_in_valid <= 1'b0;
            host_in_data <= 8'h00;
        end else begin
            rx_wr_q <= rx_wr_q + PW'(rx_push);
            rx_rd_q <= rx_rd_q + PW'(rx_pop);
            tx_wr_q <= tx_wr_q + PW'(tx_push);
            tx_rd_q <= tx_rd_q + PW'(tx_pop);
            rx_cnt_q <= rx_cnt_d;
            tx_cnt_q <= tx_cnt_d;
            host_out_ready <= (rx_cnt_d != FULL);
            host_in_valid <= (tx_cnt_d != '0);
            // A byte written into an empty buffer bypasses the array read
            if (tx_push && (tx_cnt_q == (tx_pop ? ONE : '0))) begin
                host_in_data <= in_byte;
            end else begin
                host_in_data <= tx_mem[tx_rd_q + PW'(tx_pop)];
            end
        end
    end

    // ------------------------------------------------------------
    // Byte source and acceptance per command
    // ------------------------------------------------------------
    logic src_ok, is_rd;
    logic [7:0] src_byte;

    always_comb begin
        src_ok = 1'b0;
        is_rd = 1'b0;
        src_byte = 8'h00;
        unique case (cmd_q)
            port_pkg::CMD_READ: begin
                is_rd = 1'b1;
                src_ok = (rx_cnt_q != '0);
                src_byte = rx_mem[rx_rd_q];
            end
            port_pkg::CMD_LINE_RD: begin
                is_rd = 1'b1;
                src_ok = 1'b1;
                src_byte = line_state_in;
            end
            port_pkg::CMD_USB_STATE: begin
                is_rd = 1'b1;
                src_ok = 1'b1;
                src_byte = {6'h00, usb_state};
            end
            port_pkg::CMD_WRITE: src_ok = (tx_cnt_q != FULL);
            port_pkg::CMD_LINE_WR: src_ok = 1'b1;
            // Storage commands and reserved codes are refused
            default: src_ok = 1'b0;
        endcase
    end

    assign rx_pop = drive_edge && (cnt_q == 3'h0) && (cmd_q == port_pkg::CMD_READ) && src_ok;
    assign tx_push = sample_edge && last && ack_q && (cmd_q == port_pkg::CMD_WRITE);

    // ------------------------------------------------------------
    // Phase control
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            phase_q <= 1'b0;
        end else if (!selected) begin
            state_q <= ST_IDLE;
            phase_q <= 1'b0;
        end else begin
            if (link_edge && state_q != ST_IDLE) begin
                phase_q <= !phase_q;
            end
            unique case (state_q)
                ST_IDLE: state_q <= ST_CMD;
                ST_CMD: if (link_edge && phase_q) state_q <= ST_DATA;
                ST_DATA: state_q <= ST_DATA;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command capture
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= 4'h0;
            wl_q <= port_pkg::WL_1;
            flush_req <= 1'b0;
        end else begin
            flush_req <= 1'b0;
            if (state_q == ST_CMD && link_edge && phase_q) begin
                cmd_q <= {d_q[port_pkg::CMD3_POS], d_q[port_pkg::CMD2_POS],
                          d_q[port_pkg::CMD1_POS], d_q[port_pkg::CMD0_POS]};
                // Flag lines only, command bits sit on lines 0, 3, 5 and 6
                if (!d_q[port_pkg::FLAG8_POS]) begin
                    wl_q <= port_pkg::WL_8;
                end else if (!d_q[port_pkg::FLAG4_POS]) begin
                    wl_q <= port_pkg::WL_4;
                end else if (!d_q[port_pkg::FLAG2_POS]) begin
                    wl_q <= port_pkg::WL_2;
                end else begin
                    wl_q <= port_pkg::WL_1;
                end
                flush_req <= ({d_q[port_pkg::CMD3_POS], d_q[port_pkg::CMD2_POS],
                               d_q[port_pkg::CMD1_POS], d_q[port_pkg::CMD0_POS]}
                              == port_pkg::CMD_FLUSH);
            end
        end
    end

    // ------------------------------------------------------------
    // Data phase and pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            line_state_out <= 8'h00;
            link.s_data <= 8'h00;
            link.s_oe <= 8'h00;
            link.s_stat <= 1'b0;
            link.s_stat_oe <= 1'b0;
        end else if (state_q == ST_IDLE && !selected) begin
            cnt_q <= 3'h0;
            ack_q <= 1'b0;
            link.s_oe <= port_pkg::IDLE_LINE_OE;
            link.s_data <= {7'h00, (tx_cnt_q != FULL)};
            link.s_stat <= (rx_cnt_q != '0);
            link.s_stat_oe <= 1'b1;
        end else if (state_q != ST_DATA) begin
            link.s_oe <= 8'h00; // Turnaround before the master's first edge
        end else begin
            if (drive_edge && cnt_q == 3'h0) begin
                ack_q <= src_ok;
                link.s_stat <= src_ok ? port_pkg::ACK : port_pkg::NAK;
                if (is_rd) begin
                    sh_q <= port_pkg::shift_out(src_byte, wl_q, LSB_FIRST);
                    link.s_data <= port_pkg::lane_out(src_byte, wl_q, LSB_FIRST);
                    link.s_oe <= src_ok ? port_pkg::lane_mask(wl_q) : 8'h00;
                end
            end else if (drive_edge && is_rd) begin
                sh_q <= port_pkg::shift_out(sh_q, wl_q, LSB_FIRST);
                link.s_data <= port_pkg::lane_out(sh_q, wl_q, LSB_FIRST);
            end
            if (sample_edge) begin
                cnt_q <= last ? 3'h0 : cnt_q + 3'h1;
                if (!is_rd) begin
                    sh_q <= in_byte;
                end
                if (last && ack_q && cmd_q == port_pkg::CMD_LINE_WR) begin
                    line_state_out <= in_byte;
                end
            end
        end
    end
endmodule // port_slave

// File: design/port_master.sv
`timescale 1ns/1ps
module port_master #(
    parameter int HALF = port_pkg::HALF_CYCLES,
    parameter bit LSB_FIRST = 1'b1,
    parameter bit IDLE_LEVEL = 1'b0
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Link
    port_link_if.master link,
    // Request
    input wire logic req_valid,
    input wire logic [3:0] req_cmd,
    input wire logic [1:0] req_width,
    input wire logic [7:0] req_len,
    output logic req_ready,
    // Write data, next byte taken on wr_take
    input wire logic [7:0] wr_data,
    output logic wr_take,
    // Read data
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Completion and idle status
    output logic done,
    output logic nak,
    output logic room,
    output logic avail
);
    typedef enum logic [1:0] {M_IDLE, M_LEAD, M_RUN, M_TRAIL} mstate_t;
    localparam int DW = $clog2(HALF + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(HALF - 1);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [7:0] l_meta_q, l_q;
    logic [1:0] st_sync_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            l_meta_q <= 8'hFF;
            l_q <= 8'hFF;
            st_sync_q <= 2'h3;
        end else begin
            l_meta_q <= link.lines;
            l_q <= l_meta_q;
            st_sync_q <= {st_sync_q[0], link.stat};
        end
    end

    mstate_t state_q;
    logic [DW-1:0] div_q;
    logic phase_q, cmd_stage_q, is_rd_q;
    logic [3:0] cmd_q;
    logic [1:0] wl_q;
    logic [7:0] len_q, bytes_q, sh_q;
    logic [2:0] cnt_q;
    wire tick = (div_q == DIV_LAST);
    wire last = (cnt_q == port_pkg::last_chunk(wl_q));
    wire [7:0] in_byte = port_pkg::shift_in(sh_q, l_q, wl_q, LSB_FIRST);

    // Command byte: width flag low (no flag for one line), unused positions high
    logic [7:0] cmd_byte;
    always_comb begin
        cmd_byte = port_pkg::ALL_LINES;
        cmd_byte[port_pkg::CMD3_POS] = cmd_q[3];
        cmd_byte[port_pkg::CMD2_POS] = cmd_q[2];
        cmd_byte[port_pkg::CMD1_POS] = cmd_q[1];
        cmd_byte[port_pkg::CMD0_POS] = cmd_q[0];
        unique case (wl_q)
            port_pkg::WL_2: cmd_byte[port_pkg::FLAG2_POS] = 1'b0;
            port_pkg::WL_4: cmd_byte[port_pkg::FLAG4_POS] = 1'b0;
            port_pkg::WL_8: cmd_byte[port_pkg::FLAG8_POS] = 1'b0;
            port_pkg::WL_1: cmd_byte[port_pkg::FLAG2_POS] = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= M_IDLE;
            div_q <= '0;
            phase_q <= 1'b0;
            cmd_stage_q <= 1'b0;
            is_rd_q <= 1'b0;
            cmd_q <= 4'h0;
            wl_q <= port_pkg::WL_1;
            len_q <= 8'h00;
            bytes_q <= 8'h00;
            sh_q <= 8'h00;
            cnt_q <= 3'h0;
            req_ready <= 1'b1;
            wr_take <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            done <= 1'b0;
            nak <= 1'b0;
            room <= 1'b0;
            avail <= 1'b0;
            link.link_clk <= IDLE_LEVEL;
            link.sel_n <= 1'b1;
            link.m_data <= 8'hFF;
            link.m_oe <= 8'h00;
        end else begin
            wr_take <= 1'b0;
            rd_valid <= 1'b0;
            done <= 1'b0;
            div_q <= (state_q == M_IDLE || tick) ? '0 : div_q + DW'(1);
            unique case (state_q)
                M_IDLE: begin
                    room <= l_q[0];
                    avail <= st_sync_q[1];
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        cmd_q <= req_cmd;
                        wl_q <= req_width;
                        len_q <= req_len;
                        is_rd_q <= (req_cmd == port_pkg::CMD_READ) ||
                                   (req_cmd == port_pkg::CMD_LINE_RD) ||
                                   (req_cmd == port_pkg::CMD_USB_STATE);
                        bytes_q <= 8'h00;
                        cnt_q <= 3'h0;
                        phase_q <= 1'b0;
                        cmd_stage_q <= 1'b1;
                        nak <= 1'b0;
                        link.sel_n <= 1'b0;
                        state_q <= M_LEAD;
                    end
                end
                M_LEAD: if (tick) state_q <= M_RUN;
                M_RUN: if (tick) begin
                    link.link_clk <= !link.link_clk;
                    phase_q <= !phase_q;
                    if (!phase_q) begin
                        if (cmd_stage_q) begin
                            link.m_data <= cmd_byte;
                            link.m_oe <= port_pkg::ALL_LINES;
                        end else if (!is_rd_q) begin
                            if (cnt_q == 3'h0) begin
                                wr_take <= 1'b1;
                                sh_q <= port_pkg::shift_out(wr_data, wl_q, LSB_FIRST);
                                link.m_data <= port_pkg::lane_out(wr_data, wl_q, LSB_FIRST);
                            end else begin
                                sh_q <= port_pkg::shift_out(sh_q, wl_q, LSB_FIRST);
                                link.m_data <= port_pkg::lane_out(sh_q, wl_q, LSB_FIRST);
                            end
                            link.m_oe <= port_pkg::lane_mask(wl_q);
                        end else begin
                            // Released after the slave took the command, not with its edge
                            link.m_oe <= 8'h00;
                        end
                    end else if (cmd_stage_q) begin
                        cmd_stage_q <= 1'b0;
                        if (len_q == 8'h00) begin
                            state_q <= M_TRAIL;
                        end
                    end else if (cnt_q == 3'h0 && st_sync_q[1] == port_pkg::NAK) begin
                        nak <= 1'b1;
                        state_q <= M_TRAIL;
                    end else begin
                        cnt_q <= last ? 3'h0 : cnt_q + 3'h1;
                        if (is_rd_q) begin
                            sh_q <= in_byte;
                        end
                        if (last) begin
                            bytes_q <= bytes_q + 8'h01;
                            rd_valid <= is_rd_q;
                            rd_data <= in_byte;
                            if (bytes_q + 8'h01 == len_q) begin
                                state_q <= M_TRAIL;
                            end
                        end
                    end
                end
                M_TRAIL: begin
                    link.sel_n <= 1'b1;
                    link.m_oe <= 8'h00;
                    if (tick) begin
                        done <= 1'b1;
                        req_ready <= 1'b1;
                        state_q <= M_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // port_master

// File: sim/port_asserts.sv
`timescale 1ns/1ps
// ----------------
// Link checks
// ----------------
module port_asserts (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Link wires
    input wire logic link_clk,
    input wire logic sel_n,
    input wire logic [7:0] m_oe,
    input wire logic [7:0] s_oe,
    input wire logic s_stat_oe,
    input wire logic stat
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_idle_oe; sel_n [*5] |-> s_oe == 8'h01; endproperty
    property p_stat_on; !sel_n |-> s_stat_oe; endproperty
    property p_no_fight; 1'b1 |-> (m_oe & s_oe) == 8'h00; endproperty
    property p_clk_idle; sel_n && $past(sel_n) |-> link_clk == 1'b0; endproperty
    property p_lead; $fell(sel_n) |-> !link_clk [*8]; endproperty
    property p_release; $rose(sel_n) |-> ##[1:4] s_oe == 8'h01; endproperty
    property p_master_idle; sel_n && $past(sel_n) |-> m_oe == 8'h00; endproperty
    property p_cmd_full; $fell(sel_n) |-> ##[8:40] m_oe == 8'hFF; endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("idle lines wrong");
    a_stat_on: assert property (p_stat_on) else $error("status not driven");
    a_no_fight: assert property (p_no_fight) else $error("both drive");
    a_clk_idle: assert property (p_clk_idle) else $error("clock not idle");
    a_lead: assert property (p_lead) else $error("early clock edge");
    a_release: assert property (p_release) else $error("slow release");
    a_master_idle: assert property (p_master_idle) else $error("master drives");
    a_cmd_full: assert property (p_cmd_full) else $error("command not full");
    c_select: cover property ($fell(sel_n));
    c_refuse: cover property (!sel_n && stat);
    c_wide: cover property (s_oe == 8'hFF);
endmodule // port_asserts

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0, rst_n = 1'b0, req_valid = 1'b0, host_out_valid = 1'b0;
    logic host_in_ready = 1'b0, flush_seen = 1'b0;
    logic [3:0] req_cmd = 4'h0;
    logic [1:0] req_width = 2'h0;
    logic [7:0] req_len = 8'h00, wr_data = 8'h00, host_out_data = 8'h00, rd_last = 8'h00;
    logic [7:0] line_state_out, host_in_data, rd_data;
    logic req_ready, wr_take, rd_valid, done, nak, room, avail;
    logic host_out_ready, host_in_valid, flush_req;
    int fail_count = 0;
    int num_checks = 0;
    port_link_if link_if ();
    port_slave u_port_slave (.clock(clock), .rst_n(rst_n), .link(link_if),
        .host_out_valid(host_out_valid), .host_out_data(host_out_data),
        .host_out_ready(host_out_ready), .host_in_valid(host_in_valid),
        .host_in_data(host_in_data), .host_in_ready(host_in_ready),
        .line_state_in(8'h96), .line_state_out(line_state_out), .usb_state(2'h2),
        .flush_req(flush_req));
    port_master u_port_master (.clock(clock), .rst_n(rst_n), .link(link_if),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_width(req_width), .req_len(req_len),
        .req_ready(req_ready), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
        .rd_valid(rd_valid), .done(done), .nak(nak), .room(room), .avail(avail));
    port_asserts u_port_asserts (.clock(clock), .rst_n(rst_n), .link_clk(link_if.link_clk),
        .sel_n(link_if.sel_n), .m_oe(link_if.m_oe), .s_oe(link_if.s_oe),
        .s_stat_oe(link_if.s_stat_oe), .stat(link_if.stat));
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        if (rd_valid === 1'b1) rd_last <= rd_data;
        if (flush_req === 1'b1) flush_seen <= 1'b1;
    end
    // ----------------
    // Tasks
    // ----------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // The wait for done is bounded at 4000 cycles so a stuck link cannot hang it; the req_ready wait is not
    task automatic xfer(input logic [3:0] c, input logic [1:0] w, input logic [7:0] n,
                        input logic [7:0] d);
        int k;
        req_cmd <= c;
        req_width <= w;
        req_len <= n;
        wr_data <= d;
        req_valid <= 1'b1;
        @(posedge clock);
        while (req_ready !== 1'b1) @(posedge clock);
        req_valid <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 4000) begin
            @(posedge clock);
            k++;
        end
        if (k >= 4000) fail_count++;
        repeat (4) @(posedge clock);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #600000;
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        chk({6'h0, room, avail}, 8'h02);
        for (int w = 0; w < 4; w++) begin
            xfer(port_pkg::CMD_WRITE, 2'(w), 8'h01, 8'h3C + 8'(w));
            chk({7'h0, host_in_valid}, 8'h01);
            chk(host_in_data, 8'h3C + 8'(w));
            host_in_ready <= 1'b1;
            @(posedge clock);
            host_in_ready <= 1'b0;
        end
        $display("test write done");
        xfer(port_pkg::CMD_READ, 2'h3, 8'h01, 8'h00);
        chk({7'h0, nak}, 8'h01);
        for (int i = 0; i < 5; i++) begin
            host_out_valid <= 1'b1;
            host_out_data <= 8'hC0 + 8'(i);
            @(posedge clock);
            while (host_out_ready !== 1'b1) @(posedge clock);
        end
        host_out_valid <= 1'b0;
        repeat (6) @(posedge clock);
        chk({7'h0, avail}, 8'h01);
        xfer(port_pkg::CMD_READ, 2'h3, 8'h02, 8'h00);
        chk(rd_last, 8'hC1);
        for (int w = 0; w < 3; w++) begin
            xfer(port_pkg::CMD_READ, 2'(w), 8'h01, 8'h00);
            chk(rd_last, 8'hC2 + 8'(w));
        end
        $display("test read done");
        xfer(port_pkg::CMD_LINE_WR, 2'h3, 8'h01, 8'h5A);
        chk(line_state_out, 8'h5A);
        xfer(port_pkg::CMD_LINE_RD, 2'h1, 8'h01, 8'h00);
        chk(rd_last, 8'h96);
        xfer(port_pkg::CMD_USB_STATE, 2'h0, 8'h01, 8'h00);
        chk(rd_last, 8'h02);
        xfer(port_pkg::CMD_FLUSH, 2'h2, 8'h00, 8'h00);
        chk({7'h0, flush_seen}, 8'h01);
        xfer(4'h9, 2'h1, 8'h01, 8'h00);
        chk({7'h0, nak}, 8'h01);
        $display("test commands done");
        finish_test();
    end
endmodule // testbench
